// File: logic/cdcu_pkg.sv
// constants for the character display command unit
package cdcu_pkg;
  // clock and execution times
  localparam int CLK_MHZ        = 10;
  localparam int T_LONG_NS      = 1530000;  // clear and home, 1.53 ms
  localparam int T_CMD_NS       = 39000;    // ordinary commands, 39 us
  localparam int T_DATA_NS      = 43000;    // ram data transfer, 43 us
  localparam int CYC_LONG       = (T_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_CMD        = (T_CMD_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_DATA       = (T_DATA_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 15;
  // memory sizes
  localparam int TEXT_DEPTH     = 80;
  localparam int GLYPH_DEPTH    = 64;
  localparam int VIS_CHARS      = 8;
  localparam logic [6:0] TEXT_LAST = 7'h4f;
  localparam logic [7:0] CLEAR_CODE = 8'h00;
  // command bit positions
  localparam int B_CLEAR = 0;
  localparam int B_HOME  = 1;
  localparam int B_ENTRY = 2;
  localparam int B_DISP  = 3;
  localparam int B_SHIFT = 4;
  localparam int B_FUNC  = 5;
  localparam int B_GADDR = 6;
  localparam int B_TADDR = 7;
  localparam int BUSY_BIT = 7;
  // reset values of the mode bits
  localparam logic RST_STEP_UP  = 1'b1;
  localparam logic RST_BUS8     = 1'b1;
  typedef enum {ST_IDLE, ST_CLEAR, ST_WAIT} cdcu_state_t;
endpackage : cdcu_pkg

// File: logic/cdcu_top.sv
// command decoder and ram core of the eight character display unit
`timescale 1ns/1ps
`default_nettype none
module cdcu_top (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       instr_data_select_i,
  input  wire logic       read_not_write_i,
  input  wire logic       strobe_i,
  input  wire logic [7:0] bus_bits_i,
  output logic      [7:0] bus_bits_o,
  output logic            bus_bits_oe_o,
  output logic            busy_flag_o,
  output logic            display_on_o,
  output logic            cursor_on_o,
  output logic            blink_on_o,
  output logic            bus_width_sel_o,
  output logic            two_lines_o,
  output logic            tall_font_o,
  output logic            step_up_o,
  output logic            whole_view_scroll_o,
  output logic      [6:0] view_offset_o,
  input  wire logic [2:0] view_pos_i,
  output logic      [7:0] view_code_o,
  output logic            view_from_glyph_o,
  input  wire logic [2:0] glyph_row_i,
  output logic      [7:0] glyph_row_o
);
  // ==========================================================
  // storage and state
  logic [7:0]  text_ram [cdcu_pkg::TEXT_DEPTH];
  logic [7:0]  glyph_ram [cdcu_pkg::GLYPH_DEPTH];
  logic [6:0]  addr_counter_reg;
  logic        sel_glyph_reg;
  logic        busy_reg;
  logic [cdcu_pkg::CNT_W-1:0] cnt_reg;
  cdcu_pkg::cdcu_state_t state_reg;
  logic [6:0]  clr_idx_reg;
  logic [7:0]  command_holding_reg;
  logic [6:0]  view_offset_reg;
  // access decode
  logic cmd_wr, stat_rd, dat_wr, dat_rd, accept;
  logic [7:0] c;
  logic [6:0] step_addr;
  logic [6:0] shift_addr;
  logic [7:0] vcode;
  logic [6:0] vaddr;

  assign c       = bus_bits_i;
  assign accept  = strobe_i && !busy_reg;
  assign cmd_wr  = accept && !instr_data_select_i && !read_not_write_i;
  // status read needs no idle state
  assign stat_rd = strobe_i && !instr_data_select_i && read_not_write_i;
  assign dat_wr  = accept && instr_data_select_i && !read_not_write_i;
  assign dat_rd  = accept && instr_data_select_i && read_not_write_i;

  // address step helper, wraps inside the selected ram
  function automatic logic [6:0] next_addr(input logic [6:0] a,
                                           input logic up,
                                           input logic glyph);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (glyph) begin
      r = {1'b0, r[5:0]};
    end else if (up && a == cdcu_pkg::TEXT_LAST) begin
      r = 7'h00;
    end else if (!up && a == 7'h00) begin
      r = cdcu_pkg::TEXT_LAST;
    end
    return r;
  endfunction : next_addr

  assign step_addr  = next_addr(addr_counter_reg, step_up_o, sel_glyph_reg);
  assign shift_addr = next_addr(addr_counter_reg, c[2], sel_glyph_reg);

  // ==========================================================
  // command holding and busy timer
  // commands ignored while busy
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      command_holding_reg <= 8'h00;
    end else if (cmd_wr) begin
      command_holding_reg <= c;
    end
  end

  // busy state machine with execution counts
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= cdcu_pkg::ST_IDLE;
      busy_reg  <= 1'b0;
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        cdcu_pkg::ST_IDLE: begin
          if (cmd_wr) begin
            busy_reg  <= 1'b1;
            state_reg <= c[7:1] == 7'h00 ? cdcu_pkg::ST_CLEAR
                                         : cdcu_pkg::ST_WAIT;
            cnt_reg <= c[7:2] == 6'h00
                       ? cdcu_pkg::CNT_W'(cdcu_pkg::CYC_LONG - 1)
                       : cdcu_pkg::CNT_W'(cdcu_pkg::CYC_CMD - 1);
          end else if (dat_wr || dat_rd) begin
            busy_reg  <= 1'b1;
            state_reg <= cdcu_pkg::ST_WAIT;
            cnt_reg   <= cdcu_pkg::CNT_W'(cdcu_pkg::CYC_DATA - 1);
          end
        end
        cdcu_pkg::ST_CLEAR, cdcu_pkg::ST_WAIT: begin
          if (cnt_reg == '0) begin
            busy_reg  <= 1'b0;
            state_reg <= cdcu_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end
  // ==========================================================
  // mode latches
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      step_up_o           <= cdcu_pkg::RST_STEP_UP;
      whole_view_scroll_o <= 1'b0;
      display_on_o        <= 1'b0;
      cursor_on_o         <= 1'b0;
      blink_on_o          <= 1'b0;
      bus_width_sel_o     <= cdcu_pkg::RST_BUS8;
      two_lines_o         <= 1'b0;
      tall_font_o         <= 1'b0;
    end else if (cmd_wr) begin
      if (c[7:3] == 5'h00 && c[cdcu_pkg::B_ENTRY]) begin
        step_up_o           <= c[1];
        whole_view_scroll_o <= c[0];
      end
      if (c[7:4] == 4'h0 && c[cdcu_pkg::B_DISP]) begin
        display_on_o <= c[2];
        cursor_on_o  <= c[1];
        blink_on_o   <= c[0];
      end
      if (c[7:6] == 2'h0 && c[cdcu_pkg::B_FUNC]) begin
        bus_width_sel_o <= c[4];
        two_lines_o     <= c[3];
        tall_font_o     <= c[2];
      end
    end
  end
  // ==========================================================
  // address counter, ram select and display shift
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      addr_counter_reg <= 7'h00;
      sel_glyph_reg    <= 1'b0;
      view_offset_reg  <= 7'h00;
    end else if (cmd_wr) begin
      if (c[cdcu_pkg::B_TADDR]) begin
        addr_counter_reg <= c[6:0];
        sel_glyph_reg    <= 1'b0;
      end else if (c[cdcu_pkg::B_GADDR]) begin
        addr_counter_reg <= {1'b0, c[5:0]};
        sel_glyph_reg    <= 1'b1;
      end else if (c[7:5] == 3'h0 && c[cdcu_pkg::B_SHIFT]) begin
        if (c[3]) begin
          view_offset_reg <= c[2] ? view_offset_reg - 7'h01
                                  : view_offset_reg + 7'h01;
        end else begin
          addr_counter_reg <= shift_addr;
        end
      end else if (c[7:1] == 7'h00 || c[7:2] == 6'h00) begin
        // clear and home zero the counter
        addr_counter_reg <= 7'h00;
        sel_glyph_reg    <= 1'b0;
        view_offset_reg  <= 7'h00;
      end
    end else if (dat_wr || dat_rd) begin
      addr_counter_reg <= step_addr;
    end
  end
  // ==========================================================
  // ram writes and clear sweep
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clr_idx_reg <= 7'h00;
    end else if (state_reg == cdcu_pkg::ST_CLEAR) begin
      // fill text ram one cell per clock
      if (clr_idx_reg != cdcu_pkg::TEXT_LAST + 7'h01) begin
        text_ram[clr_idx_reg] <= cdcu_pkg::CLEAR_CODE;
        clr_idx_reg           <= clr_idx_reg + 7'h01;
      end
    end else begin
      clr_idx_reg <= 7'h00;
      if (dat_wr && sel_glyph_reg) begin
        glyph_ram[addr_counter_reg[5:0]] <= c;
      end else if (dat_wr && addr_counter_reg <= cdcu_pkg::TEXT_LAST) begin
        text_ram[addr_counter_reg] <= c;
      end
    end
  end
  // ==========================================================
  // read path
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_bits_o <= 8'h00;
    end else begin
      if (dat_rd) begin
        bus_bits_o <= sel_glyph_reg
          ? glyph_ram[addr_counter_reg[5:0]]
          : (addr_counter_reg <= cdcu_pkg::TEXT_LAST
             ? text_ram[addr_counter_reg] : 8'h00);
      end else if (stat_rd) begin
        bus_bits_o <= {busy_reg, addr_counter_reg};
      end
    end
  end

  assign bus_bits_oe_o = strobe_i && read_not_write_i;
  assign busy_flag_o   = busy_reg;
  assign view_offset_o = view_offset_reg;
  // ==========================================================
  // view lookup for the panel driver
  // visible positions map to text addresses 00 to 07 plus view_offset_reg, modulo 80
  assign vaddr = 7'(({4'h0, view_pos_i} + view_offset_reg)
                 % cdcu_pkg::TEXT_DEPTH);
  assign vcode = text_ram[vaddr];
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      view_code_o       <= 8'h00;
      view_from_glyph_o <= 1'b0;
      glyph_row_o       <= 8'h00;
    end else begin
      view_code_o       <= vcode;
      // low codes use glyph ram, bit 3 ignored
      view_from_glyph_o <= vcode[7:4] == 4'h0;
      glyph_row_o       <= glyph_ram[{vcode[2:0], glyph_row_i}];
    end
  end
  // ==========================================================
  // checks
  sequence s_cmd_taken;
    cmd_wr && c[7:2] != 6'h00;
  endsequence
  a_busy_after_cmd: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_cmd_taken |=> busy_reg [*8]) else $error("busy dropped early");
  a_status_value: assert property (@(posedge mclk_i) disable iff (rst_i)
    stat_rd |=> bus_bits_o == $past({busy_reg, addr_counter_reg}))
    else $error("status byte wrong");
  a_text_addr_set: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_wr && c[7] |=> addr_counter_reg == $past(c[6:0]) && !sel_glyph_reg)
    else $error("text address not loaded");
  a_glyph_addr_set: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_wr && c[7:6] == 2'b01 |=> sel_glyph_reg
      && addr_counter_reg == {1'b0, $past(c[5:0])})
    else $error("glyph address not loaded");
  a_clear_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_wr && c == 8'h01 |=> addr_counter_reg == 7'h00
      && state_reg == cdcu_pkg::ST_CLEAR) else $error("clear failed");
  a_cmd_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy_reg && strobe_i && !read_not_write_i |=> $stable(command_holding_reg)
      && $stable(addr_counter_reg)) else $error("write taken while busy");
  a_entry_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_wr && c[7:2] == 6'h01 |=> step_up_o == $past(c[1]))
    else $error("entry mode not latched");
  a_data_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    dat_wr && !sel_glyph_reg && step_up_o && addr_counter_reg < 7'h4f
      |=> addr_counter_reg == $past(addr_counter_reg) + 7'h01)
    else $error("address did not step");
endmodule : cdcu_top
`default_nettype wire

// File: bench/cdcu_host.sv
// host processor model driving the display unit's parallel port
`timescale 1ns/1ps
`default_nettype none
module cdcu_host (
  input  wire logic       clk_i,
  input  wire logic       busy_i,
  output var  logic       ids_o,
  output var  logic       rw_o,
  output var  logic       stb_o,
  output var  logic [7:0] bus_o
);
  // ==========================================================
  // idle levels at time zero
  initial begin
    ids_o = 1'b0;
    rw_o  = 1'b0;
    stb_o = 1'b0;
    bus_o = 8'h00;
  end

  // ==========================================================
  // one strobed access, held until its taking edge
  task automatic access(input logic ids, input logic rw, input logic [7:0] d);
    @(posedge clk_i);
    ids_o <= ids;
    rw_o  <= rw;
    stb_o <= 1'b1;
    bus_o <= d;
    @(posedge clk_i);
    stb_o <= 1'b0;
    bus_o <= ~d;  // released byte no longer shows the old value
  endtask : access

  task automatic wait_idle(output int n);
    n = 0;
    @(negedge clk_i);
    while (busy_i === 1'b1 && n < 20000) begin
      n++;
      @(negedge clk_i);
    end
  endtask : wait_idle
endmodule : cdcu_host
`default_nettype wire

// File: bench/cdcu_top_tb.sv
// self-checking bench for the display command unit
`timescale 1ns/1ps
`default_nettype none
module cdcu_top_tb;
  logic       mclk_i, rst_i, ids, rw, stb, oe, busy, rd_seen;
  logic       d_on, c_on, b_on, bw, two, tall, up, scr, from_g;
  logic [7:0] bus_w, bus_r, code, grow, p;
  logic [6:0] voff;
  logic [2:0] vpos, gsel;
  logic [7:0] exp_q[$];
  logic [7:0] d[3];
  int         error_cnt, cmp_count, cyc_cnt, wait_n;

  cdcu_top u_cdcu_top (.mclk_i(mclk_i), .rst_i(rst_i),
    .instr_data_select_i(ids), .read_not_write_i(rw), .strobe_i(stb),
    .bus_bits_i(bus_w), .bus_bits_o(bus_r), .bus_bits_oe_o(oe),
    .busy_flag_o(busy), .display_on_o(d_on), .cursor_on_o(c_on),
    .blink_on_o(b_on), .bus_width_sel_o(bw), .two_lines_o(two),
    .tall_font_o(tall), .step_up_o(up), .whole_view_scroll_o(scr),
    .view_offset_o(voff), .view_pos_i(vpos), .view_code_o(code),
    .view_from_glyph_o(from_g), .glyph_row_i(gsel), .glyph_row_o(grow));
  cdcu_host u_cdcu_host (.clk_i(mclk_i), .busy_i(busy), .ids_o(ids),
    .rw_o(rw), .stb_o(stb), .bus_o(bus_w));

  // ==========================================================
  // clock and cycle ceiling
  initial mclk_i = 1'b0;
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      test_done();
    end
  end

  // ==========================================================
  // comparisons and verdict
  task automatic chk_read(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
    end
  endtask : chk_read
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t port %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ==========================================================
  // read monitor takes the oldest note per returned byte
  always @(posedge mclk_i) rd_seen <= stb & rw;
  always @(negedge mclk_i) begin
    if (rd_seen === 1'b1) begin
      chk_read(bus_r, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
    if (stb === 1'b1) begin
      chk(16'(oe), 16'(rw));
    end
  end

  // ==========================================================
  // access, status while busy, busy span, status when idle
  task automatic op(input logic ids_v, input logic rw_v, input logic [7:0] dv,
                    input logic [7:0] rx, input logic [6:0] st, input int cyc);
    int n;
    if (rw_v) exp_q.push_back(rx);
    u_cdcu_host.access(ids_v, rw_v, dv);
    exp_q.push_back({1'b1, st});
    u_cdcu_host.access(1'b0, 1'b1, 8'h00);
    u_cdcu_host.wait_idle(n);
    chk(16'(n + 2), 16'(cyc));
    exp_q.push_back({1'b0, st});
    u_cdcu_host.access(1'b0, 1'b1, 8'h00);
  endtask : op
  // panel position and glyph row, sampled once registered
  task automatic view(input logic [2:0] pos, input logic [2:0] row);
    @(posedge mclk_i);
    vpos <= pos;
    gsel <= row;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : view

  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    vpos  = 3'h0;
    gsel  = 3'h0;
    void'($urandom(32'h7634));
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk(16'({up, bw, d_on, busy}), 16'h000c);
    op(1'b0, 1'b0, 8'h2c, 8'h00, 7'h00, cdcu_pkg::CYC_CMD);
    chk(16'({bw, two, tall}), 16'h0003);
    // wide bus function set must leave the address counter alone
    op(1'b0, 1'b0, 8'h38, 8'h00, 7'h00, cdcu_pkg::CYC_CMD);
    chk(16'({bw, two, tall}), 16'h0006);
    op(1'b0, 1'b0, 8'h0d, 8'h00, 7'h00, cdcu_pkg::CYC_CMD);
    chk(16'({d_on, c_on, b_on}), 16'h0005);
    op(1'b0, 1'b0, 8'h07, 8'h00, 7'h00, cdcu_pkg::CYC_CMD);
    chk(16'({up, scr}), 16'h0003);
    op(1'b0, 1'b0, 8'h06, 8'h00, 7'h00, cdcu_pkg::CYC_CMD);
    chk(16'({up, scr}), 16'h0002);
    op(1'b0, 1'b0, 8'h85, 8'h00, 7'h05, cdcu_pkg::CYC_CMD);
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($urandom);
      op(1'b1, 1'b0, d[i], 8'h00, 7'(6 + i), cdcu_pkg::CYC_DATA);
    end
    // byte 55 lands at 08, the clear right behind it is refused
    u_cdcu_host.access(1'b1, 1'b0, 8'h55);
    u_cdcu_host.access(1'b0, 1'b0, 8'h01);
    u_cdcu_host.wait_idle(wait_n);
    chk(16'(wait_n + 2), 16'(cdcu_pkg::CYC_DATA));
    op(1'b1, 1'b0, 8'haa, 8'h00, 7'h0a, cdcu_pkg::CYC_DATA);
    op(1'b0, 1'b0, 8'h85, 8'h00, 7'h05, cdcu_pkg::CYC_CMD);
    for (int i = 0; i < 3; i++) begin
      op(1'b1, 1'b1, 8'h00, d[i], 7'(6 + i), cdcu_pkg::CYC_DATA);
    end
    op(1'b1, 1'b1, 8'h00, 8'h55, 7'h09, cdcu_pkg::CYC_DATA);
    view(3'h5, 3'h0);
    chk(16'(code), 16'(d[0]));
    chk(16'(from_g), 16'(d[0][7:4] == 4'h0));
    op(1'b0, 1'b0, 8'h04, 8'h00, 7'h09, cdcu_pkg::CYC_CMD);
    op(1'b0, 1'b0, 8'h83, 8'h00, 7'h03, cdcu_pkg::CYC_CMD);
    op(1'b1, 1'b0, 8'h33, 8'h00, 7'h02, cdcu_pkg::CYC_DATA);
    op(1'b0, 1'b0, 8'h18, 8'h00, 7'h02, cdcu_pkg::CYC_CMD);
    chk(16'(voff), 16'h0001);
    op(1'b0, 1'b0, 8'h14, 8'h00, 7'h03, cdcu_pkg::CYC_CMD);
    chk(16'(voff), 16'h0001);
    op(1'b0, 1'b0, 8'h03, 8'h00, 7'h00, cdcu_pkg::CYC_LONG);
    chk(16'(voff), 16'h0000);
    op(1'b0, 1'b0, 8'h85, 8'h00, 7'h05, cdcu_pkg::CYC_CMD);
    op(1'b1, 1'b1, 8'h00, d[0], 7'h04, cdcu_pkg::CYC_DATA);
    op(1'b0, 1'b0, 8'h06, 8'h00, 7'h04, cdcu_pkg::CYC_CMD);
    op(1'b0, 1'b0, 8'h48, 8'h00, 7'h08, cdcu_pkg::CYC_CMD);
    p = 8'($urandom);
    op(1'b1, 1'b0, p, 8'h00, 7'h09, cdcu_pkg::CYC_DATA);
    op(1'b0, 1'b0, 8'h80, 8'h00, 7'h00, cdcu_pkg::CYC_CMD);
    op(1'b1, 1'b0, 8'h09, 8'h00, 7'h01, cdcu_pkg::CYC_DATA);
    view(3'h0, 3'h0);
    chk(16'({from_g, grow}), 16'({1'b1, p}));
    op(1'b0, 1'b0, 8'h01, 8'h00, 7'h00, cdcu_pkg::CYC_LONG);
    op(1'b0, 1'b0, 8'h85, 8'h00, 7'h05, cdcu_pkg::CYC_CMD);
    op(1'b1, 1'b1, 8'h00, 8'h00, 7'h06, cdcu_pkg::CYC_DATA);
    test_done();
  end
endmodule : cdcu_top_tb
`default_nettype wire
